/* rnc_config_poller.sv */
// Configuration registers and TDMA poll sequencer of the radio module
// Operation
// - Auto-assigned addresses (local zero): repeater flag ignored, still written zero.
// - Repeater flag acts only on master; 0 none (reset), 1 present.
// - Serial mode: 0 RS232 (reset), 1 RS485 half, 2 RS485 full.
// - Source bit 0 (reset): repeater number from repeater index, 1 to 254.
// - Source bit 1: repeater number is GPIO[4:1] plus one, 1 to 16.
// - Encryption enable: 1 on, 0 off, off at reset.
// - Request/grant: slave asks master, sends only after grant.
// - TDMA: master allocates slots, slaves send only in their slots.
// - TDMA only in point-to-multipoint and centred mesh networks.
// - Master polls from local address plus one up to maximum poll address.
// - Slave outside poll range cannot access the network.
// - Fixed 20 ms per address, slaves served in ascending order.
// - Master-to-slave traffic never waits for polling, within one slot.
// - Adaptive mode: slots by pending data, capped by slot maximum (15).
// - Master and repeater: destination names the linked subordinate unit.
// - Point-to-point: destination auto-assigned when local address zero.
// - Point-to-point master talks only to unit matching destination.
`timescale 1ns/1ns
module rnc_config_poller
  import rnc_pkg::*;
#(
  parameter int SLOT_CYCLES = RNC_SLOT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_idx_in,
  input wire logic [3:0] cfg_key_word_in,
  input wire logic [15:0] cfg_wr_data_in,
  input wire logic [15:0] local_unit_address_in,
  input wire logic [1:0] network_type_in,
  input wire logic [1:0] operating_mode_in,
  input wire logic [7:0] repeater_index_in,
  input wire logic [3:0] gpio_in,
  input wire logic [15:0] auto_dest_address_in,
  input wire logic [15:0] peer_address_in,
  input wire logic [15:0] pending_slots_in,
  input wire logic rts_in,
  input wire logic downlink_req_in,
  output logic [15:0] cfg_rd_data_out,
  output logic cfg_rd_valid_out,
  output logic cfg_err_out,
  output logic repeater_present_out,
  output logic [1:0] serial_mode_out,
  output logic rs485_out,
  output logic full_duplex_out,
  output logic [7:0] repeater_number_out,
  output logic encryption_on_out,
  output logic [255:0] encryption_key_out,
  output logic [15:0] destination_out,
  output logic peer_match_out,
  output logic tdma_active_out,
  output logic [15:0] poll_address_out,
  output logic poll_slot_out,
  output logic in_poll_range_out,
  output logic cts_grant_out,
  output logic downlink_go_out
);

  logic [15:0] dest_reg, dest_next;
  logic rpt_reg, rpt_next;
  logic [1:0] ser_reg, ser_next;
  logic src_reg, src_next;
  logic enc_reg, enc_next;
  logic [255:0] key_reg, key_next;
  logic [7:0] acc_reg, acc_next;
  logic [15:0] maxaddr_reg, maxaddr_next;
  logic [15:0] maxslots_reg, maxslots_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic err_reg, err_next;

  // Register write and read port
  always_comb begin
    dest_next = dest_reg;
    rpt_next = rpt_reg;
    ser_next = ser_reg;
    src_next = src_reg;
    enc_next = enc_reg;
    key_next = key_reg;
    acc_next = acc_reg;
    maxaddr_next = maxaddr_reg;
    maxslots_next = maxslots_reg;
    rd_data_next = 16'h0000;
    rd_valid_next = cfg_rd_in;
    err_next = 1'b0;
    if (cfg_wr_in) begin
      unique case (cfg_idx_in)
        RNC_IDX_DEST_ADDR: dest_next = cfg_wr_data_in;
        RNC_IDX_RPT_PRESENT: rpt_next = cfg_wr_data_in[0];
        RNC_IDX_SERIAL_MODE: begin
          // Code 3 is not a mode; keep the old one
          if (cfg_wr_data_in[1:0] != 2'h3) begin
            ser_next = cfg_wr_data_in[1:0];
          end else begin
            err_next = 1'b1;
          end
        end
        RNC_IDX_RPT_NUM_SRC: src_next = cfg_wr_data_in[0];
        RNC_IDX_ENC_ENABLE: enc_next = cfg_wr_data_in[0];
        RNC_IDX_ENC_KEY: key_next[cfg_key_word_in*16 +: 16] = cfg_wr_data_in;
        RNC_IDX_ACCESS_MODE: acc_next = cfg_wr_data_in[7:0];
        RNC_IDX_TDMA_MAX_ADDR: maxaddr_next = cfg_wr_data_in;
        RNC_IDX_TDMA_MAX_SLOTS: maxslots_next = cfg_wr_data_in;
        default: err_next = 1'b1;
      endcase
    end else if (cfg_rd_in) begin
      unique case (cfg_idx_in)
        RNC_IDX_DEST_ADDR: rd_data_next = dest_reg;
        RNC_IDX_RPT_PRESENT: rd_data_next = {15'h0, rpt_reg};
        RNC_IDX_SERIAL_MODE: rd_data_next = {14'h0, ser_reg};
        RNC_IDX_RPT_NUM_SRC: rd_data_next = {15'h0, src_reg};
        RNC_IDX_ENC_ENABLE: rd_data_next = {15'h0, enc_reg};
        RNC_IDX_ENC_KEY: rd_data_next = key_reg[cfg_key_word_in*16 +: 16];
        RNC_IDX_ACCESS_MODE: rd_data_next = {8'h00, acc_reg};
        RNC_IDX_TDMA_MAX_ADDR: rd_data_next = maxaddr_reg;
        RNC_IDX_TDMA_MAX_SLOTS: rd_data_next = maxslots_reg;
        default: err_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dest_reg <= RNC_RST_DEST_ADDR;
      rpt_reg <= RNC_RST_RPT_PRESENT;
      ser_reg <= RNC_RST_SERIAL_MODE;
      src_reg <= RNC_RST_RPT_NUM_SRC;
      enc_reg <= RNC_RST_ENC_ENABLE;
      key_reg <= RNC_RST_ENC_KEY;
      acc_reg <= RNC_RST_ACCESS_MODE;
      maxaddr_reg <= RNC_RST_TDMA_MAX_ADDR;
      maxslots_reg <= RNC_RST_TDMA_MAX_SLOTS;
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      dest_reg <= dest_next;
      rpt_reg <= rpt_next;
      ser_reg <= ser_next;
      src_reg <= src_next;
      enc_reg <= enc_next;
      key_reg <= key_next;
      acc_reg <= acc_next;
      maxaddr_reg <= maxaddr_next;
      maxslots_reg <= maxslots_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      err_reg <= err_next;
    end
  end

  // Derived network settings
  logic is_master, is_p2p, auto_addr, tdma_mode, tdma_ok;
  logic [15:0] poll_first;
  logic [15:0] dest_eff;
  logic in_range;

  assign is_master = (operating_mode_in == RNC_OP_MASTER);
  assign is_p2p = (network_type_in == RNC_NET_P2P);
  assign auto_addr = is_p2p && (local_unit_address_in == 16'h0000);
  assign tdma_mode = (acc_reg == RNC_ACC_TDMA) || (acc_reg == RNC_ACC_ADAPTIVE);
  assign tdma_ok = tdma_mode && !is_p2p;
  assign poll_first = local_unit_address_in + 16'h0001;
  assign dest_eff = auto_addr ? auto_dest_address_in : dest_reg;
  // Slave checks its own address against the maximum poll address only; the lower compare is against itself and always holds
  assign in_range = (local_unit_address_in >= poll_first - 16'h0001) &&
                    (local_unit_address_in <= maxaddr_reg);

  // Repeater number: GPIO value caught once after reset release
  logic [3:0] gpio_cap_reg, gpio_cap_next;
  logic cap_done_reg, cap_done_next;
  logic [7:0] rpt_num;

  always_comb begin
    gpio_cap_next = gpio_cap_reg;
    cap_done_next = 1'b1;
    if (!cap_done_reg) begin
      gpio_cap_next = gpio_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gpio_cap_reg <= 4'h0;
      cap_done_reg <= 1'b0;
    end else begin
      gpio_cap_reg <= gpio_cap_next;
      cap_done_reg <= cap_done_next;
    end
  end

  assign rpt_num = src_reg ? ({4'h0, gpio_cap_reg} + 8'h01)
                           : repeater_index_in;

  // TDMA poll sequencer
  rnc_poll_e st_reg, st_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] left_reg, left_next;
  logic [31:0] tmr_reg, tmr_next;
  logic slot_end;
  logic [15:0] grant_slots;

  assign slot_end = (tmr_reg == 32'(SLOT_CYCLES - 1));

  always_comb begin
    // Adaptive allotment, at least one, above the cap only when the cap is zero
    if (acc_reg != RNC_ACC_ADAPTIVE) begin
      grant_slots = 16'h0001;
    end else if (pending_slots_in > maxslots_reg) begin
      grant_slots = maxslots_reg;
    end else if (pending_slots_in == 16'h0000) begin
      grant_slots = 16'h0001;
    end else begin
      grant_slots = pending_slots_in;
    end
    if (grant_slots == 16'h0000) begin
      grant_slots = 16'h0001;
    end
  end

  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    tmr_next = 32'h0000_0000;
    if (!(tdma_ok && is_master) || poll_first > maxaddr_reg) begin
      st_next = RNC_ST_IDLE;
    end else begin
      unique case (st_reg)
        RNC_ST_IDLE: begin
          st_next = RNC_ST_SLOT;
          addr_next = poll_first;
          left_next = grant_slots;
        end
        RNC_ST_SLOT: begin
          tmr_next = tmr_reg + 32'h0000_0001;
          if (slot_end) begin
            tmr_next = 32'h0000_0000;
            left_next = left_reg - 16'h0001;
            if (left_reg == 16'h0001) begin
              st_next = RNC_ST_NEXT;
            end
          end
        end
        RNC_ST_NEXT: begin
          st_next = RNC_ST_SLOT;
          left_next = grant_slots;
          if (addr_reg >= maxaddr_reg) begin
            addr_next = poll_first;
          end else begin
            addr_next = addr_reg + 16'h0001;
          end
        end
        default: st_next = RNC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= RNC_ST_IDLE;
      addr_reg <= 16'h0000;
      left_reg <= 16'h0000;
      tmr_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      tmr_reg <= tmr_next;
    end
  end

  // Registered outputs
  logic [7:0] rpt_num_q;
  logic rpt_q, rs485_q, fdx_q, match_q, tdma_q, slot_q, range_q, cts_q, dl_q;
  logic [15:0] dest_q, paddr_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rpt_q <= 1'b0;
      rs485_q <= 1'b0;
      fdx_q <= 1'b0;
      rpt_num_q <= 8'h00;
      dest_q <= 16'h0000;
      match_q <= 1'b0;
      tdma_q <= 1'b0;
      paddr_q <= 16'h0000;
      slot_q <= 1'b0;
      range_q <= 1'b0;
      cts_q <= 1'b0;
      dl_q <= 1'b0;
    end else begin
      rpt_q <= rpt_reg && is_master && !auto_addr;
      rs485_q <= (ser_reg != RNC_SER_RS232);
      fdx_q <= (ser_reg == RNC_SER_RS485_FULL);
      rpt_num_q <= rpt_num;
      dest_q <= dest_eff;
      // Point-to-point master serves only its destination
      match_q <= !(is_p2p && is_master) || (peer_address_in == dest_eff);
      tdma_q <= tdma_ok;
      paddr_q <= addr_reg;
      slot_q <= (st_reg == RNC_ST_SLOT);
      range_q <= in_range;
      cts_q <= is_master && !tdma_mode && rts_in;
      // Downlink goes at once, without waiting for its poll turn
      dl_q <= is_master && downlink_req_in;
    end
  end

  assign cfg_rd_data_out = rd_data_reg;
  assign cfg_rd_valid_out = rd_valid_reg;
  assign cfg_err_out = err_reg;
  assign repeater_present_out = rpt_q;
  assign serial_mode_out = ser_reg;
  assign rs485_out = rs485_q;
  assign full_duplex_out = fdx_q;
  assign repeater_number_out = rpt_num_q;
  assign encryption_on_out = enc_reg;
  assign encryption_key_out = key_reg;
  assign destination_out = dest_q;
  assign peer_match_out = match_q;
  assign tdma_active_out = tdma_q;
  assign poll_address_out = paddr_q;
  assign poll_slot_out = slot_q;
  assign in_poll_range_out = range_q;
  assign cts_grant_out = cts_q;
  assign downlink_go_out = dl_q;

endmodule

/* rnc_pkg.sv */
// Constants and types for the radio network configuration and TDMA poller
package rnc_pkg;

  // Register numbers used by the configuration command port
  localparam logic [7:0] RNC_IDX_DEST_ADDR = 8'd140;
  localparam logic [7:0] RNC_IDX_RPT_PRESENT = 8'd141;
  localparam logic [7:0] RNC_IDX_SERIAL_MODE = 8'd142;
  localparam logic [7:0] RNC_IDX_RPT_NUM_SRC = 8'd143;
  localparam logic [7:0] RNC_IDX_ENC_ENABLE = 8'd159;
  localparam logic [7:0] RNC_IDX_ENC_KEY = 8'd160;
  localparam logic [7:0] RNC_IDX_ACCESS_MODE = 8'd244;
  localparam logic [7:0] RNC_IDX_TDMA_MAX_ADDR = 8'd221;
  localparam logic [7:0] RNC_IDX_TDMA_MAX_SLOTS = 8'd220;

  // Reset values
  localparam logic [15:0] RNC_RST_DEST_ADDR = 16'h0000;
  localparam logic RNC_RST_RPT_PRESENT = 1'b0;
  localparam logic [1:0] RNC_RST_SERIAL_MODE = 2'h0;
  localparam logic RNC_RST_RPT_NUM_SRC = 1'b0;
  localparam logic RNC_RST_ENC_ENABLE = 1'b0;
  localparam logic [255:0] RNC_RST_ENC_KEY = 256'h0;
  localparam logic [7:0] RNC_RST_ACCESS_MODE = 8'h00;
  localparam logic [15:0] RNC_RST_TDMA_MAX_ADDR = 16'h0006;
  localparam logic [15:0] RNC_RST_TDMA_MAX_SLOTS = 16'h000f;

  // Field encodings
  localparam logic [1:0] RNC_SER_RS232 = 2'h0;
  localparam logic [1:0] RNC_SER_RS485_HALF = 2'h1;
  localparam logic [1:0] RNC_SER_RS485_FULL = 2'h2;
  localparam logic [7:0] RNC_ACC_RTS_CTS = 8'h00;
  localparam logic [7:0] RNC_ACC_TDMA = 8'h01;
  localparam logic [7:0] RNC_ACC_ADAPTIVE = 8'h02;
  localparam logic [1:0] RNC_NET_P2MP = 2'h0;
  localparam logic [1:0] RNC_NET_P2P = 2'h1;
  localparam logic [1:0] RNC_NET_MESH = 2'h2;
  localparam logic [1:0] RNC_OP_MASTER = 2'h0;
  localparam logic [1:0] RNC_OP_REPEATER = 2'h1;
  localparam logic [1:0] RNC_OP_SLAVE = 2'h2;

  // Poll slot timing
  localparam int RNC_CLK_HZ = 100_000_000;
  localparam int RNC_SLOT_MS = 20;
  localparam int RNC_SLOT_CYCLES = RNC_CLK_HZ / 1000 * RNC_SLOT_MS;

  typedef enum logic [1:0] {
    RNC_ST_IDLE = 2'b00,
    RNC_ST_SLOT = 2'b01,
    RNC_ST_NEXT = 2'b11
  } rnc_poll_e;

endpackage

/* rnc_chk.sv */
// Port-level assertions for the configuration and poll sequencer
`timescale 1ns/1ns
module rnc_chk
  import rnc_pkg::*;
#(
  parameter int SLOT_CYCLES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [15:0] local_unit_address_in,
  input wire logic [1:0] network_type_in,
  input wire logic [1:0] operating_mode_in,
  input wire logic rts_in,
  input wire logic downlink_req_in,
  input wire logic cfg_rd_valid_out,
  input wire logic cfg_err_out,
  input wire logic repeater_present_out,
  input wire logic [1:0] serial_mode_out,
  input wire logic rs485_out,
  input wire logic full_duplex_out,
  input wire logic tdma_active_out,
  input wire logic [15:0] poll_address_out,
  input wire logic poll_slot_out,
  input wire logic cts_grant_out,
  input wire logic downlink_go_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [31:0] slot_cnt_reg;
  logic [31:0] slot_cnt_next;
  always_comb begin
    slot_cnt_next = poll_slot_out ? slot_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      slot_cnt_reg <= 32'h0000_0000;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
    end
  end
  sequence p2p_held;
    (network_type_in == RNC_NET_P2P) [*4];
  endsequence
  sequence slot_end;
    $fell(poll_slot_out);
  endsequence
  rd_valid_a: assert property (cfg_rd_in && !cfg_wr_in |=> cfg_rd_valid_out)
    else $error("read not answered");
  err_cause_a: assert property (cfg_err_out |-> $past(cfg_wr_in || cfg_rd_in))
    else $error("error pulse without request");
  rpt_master_a: assert property (
    $past(operating_mode_in) != RNC_OP_MASTER |-> !repeater_present_out)
    else $error("repeater flag on non-master");
  rpt_auto_a: assert property (
    $past(network_type_in == RNC_NET_P2P && local_unit_address_in == 16'h0000)
    |-> !repeater_present_out)
    else $error("repeater flag in auto addressing");
  serial_dec_a: assert property (
    serial_mode_out == $past(serial_mode_out) |->
    rs485_out == (serial_mode_out != RNC_SER_RS232) &&
    full_duplex_out == (serial_mode_out == RNC_SER_RS485_FULL))
    else $error("serial mode decode wrong");
  tdma_p2p_a: assert property (p2p_held |=> !tdma_active_out && !poll_slot_out)
    else $error("polling in point-to-point");
  cts_cause_a: assert property (
    cts_grant_out |-> $past(rts_in && operating_mode_in == RNC_OP_MASTER))
    else $error("grant without request");
  downlink_a: assert property (
    !$past(rst_in) |->
    downlink_go_out == $past(operating_mode_in == RNC_OP_MASTER && downlink_req_in))
    else $error("downlink not sent at once");
  // A live address change that puts the start above the maximum poll address stops the sequencer two cycles late
  poll_range_a: assert property (
    poll_slot_out && $past(local_unit_address_in, 2) == local_unit_address_in |->
    poll_address_out > local_unit_address_in)
    else $error("polled address below start");
  // Slots cut short by a live address change are not judged
  slot_len_a: assert property (
    slot_end ##0 $past(local_unit_address_in, 2) == $past(local_unit_address_in, 3) |->
    slot_cnt_reg != 0 && slot_cnt_reg % SLOT_CYCLES == 0)
    else $error("slot length not whole slots");
endmodule

bind rnc_config_poller rnc_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_rnc_chk (.clk_sys_in, .rst_in,
  .cfg_wr_in, .cfg_rd_in, .local_unit_address_in, .network_type_in, .operating_mode_in,
  .rts_in, .downlink_req_in, .cfg_rd_valid_out, .cfg_err_out, .repeater_present_out,
  .serial_mode_out, .rs485_out, .full_duplex_out, .tdma_active_out, .poll_address_out,
  .poll_slot_out, .cts_grant_out, .downlink_go_out);

/* rnc_host.sv */
// Host equipment model issuing configuration commands
`timescale 1ns/1ns
module rnc_host (
  input wire logic clk_in,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in,
  input wire logic err_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] idx_out,
  output logic [3:0] word_out,
  output logic [15:0] data_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    idx_out = 8'h00;
    word_out = 4'h0;
    data_out = 16'h0000;
  end
  // Released lines show inverted data (write) or index (read) so stale values never look valid
  task automatic wr(input logic [7:0] idx, input logic [3:0] word, input logic [15:0] data,
                    output logic err);
    @(negedge clk_in);
    wr_out = 1'b1;
    idx_out = idx;
    word_out = word;
    data_out = data;
    @(negedge clk_in);
    wr_out = 1'b0;
    data_out = ~data;
    err = err_in;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [15:0] data, output logic vld);
    @(negedge clk_in);
    rd_out = 1'b1;
    idx_out = idx;
    @(negedge clk_in);
    rd_out = 1'b0;
    idx_out = ~idx;
    data = rd_data_in;
    vld = rd_valid_in;
  endtask
endmodule

/* tb_rnc_config_poller.sv */
// Self-checking bench for the configuration and poll sequencer
`timescale 1ns/1ns
module tb_rnc_config_poller;
  import rnc_pkg::*;
  localparam int SLOT = 8;
  typedef struct {
    logic wr;
    logic [7:0] idx;
    logic [15:0] dat;
    logic [15:0] exp;
    logic err;
  } rnc_row_s;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_wr_in, cfg_rd_in, cfg_rd_valid_out, cfg_err_out, e, v;
  logic [7:0] cfg_idx_in;
  logic [3:0] cfg_key_word_in;
  logic [15:0] cfg_wr_data_in, cfg_rd_data_out, d, a, l;
  logic [15:0] local_unit_address_in = 16'h0001;
  logic [1:0] network_type_in = RNC_NET_P2MP;
  logic [1:0] operating_mode_in = RNC_OP_MASTER;
  logic [7:0] repeater_index_in = 8'hc8;
  logic [3:0] gpio_in = 4'h9;
  logic [15:0] auto_dest_address_in = 16'h0777;
  logic [15:0] peer_address_in = 16'h1234;
  logic [15:0] pending_slots_in = 16'h0005;
  logic rts_in = 1'b0;
  logic downlink_req_in = 1'b0;
  logic repeater_present_out, rs485_out, full_duplex_out, encryption_on_out, peer_match_out;
  logic tdma_active_out, poll_slot_out, in_poll_range_out, cts_grant_out, downlink_go_out;
  logic [1:0] serial_mode_out;
  logic [7:0] repeater_number_out;
  logic [255:0] encryption_key_out;
  logic [15:0] destination_out, poll_address_out;
  int miscompares = 0;
  int checked = 0;
  rnc_row_s rows[12] = '{
    '{1'b0, RNC_IDX_TDMA_MAX_ADDR, 16'h0000, RNC_RST_TDMA_MAX_ADDR, 1'b0},
    '{1'b0, RNC_IDX_TDMA_MAX_SLOTS, 16'h0000, RNC_RST_TDMA_MAX_SLOTS, 1'b0},
    '{1'b0, RNC_IDX_DEST_ADDR, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, RNC_IDX_RPT_PRESENT, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, RNC_IDX_SERIAL_MODE, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, RNC_IDX_ENC_ENABLE, 16'h0000, 16'h0000, 1'b0},
    '{1'b1, RNC_IDX_DEST_ADDR, 16'h1234, 16'h1234, 1'b0},
    '{1'b1, RNC_IDX_SERIAL_MODE, 16'h0001, 16'h0001, 1'b0},
    '{1'b1, RNC_IDX_SERIAL_MODE, 16'h0002, 16'h0002, 1'b0},
    '{1'b1, RNC_IDX_SERIAL_MODE, 16'h0003, 16'h0002, 1'b1},
    '{1'b1, RNC_IDX_ENC_ENABLE, 16'h0001, 16'h0001, 1'b0},
    '{1'b1, RNC_IDX_RPT_PRESENT, 16'h0001, 16'h0001, 1'b0}};
  rnc_config_poller #(.SLOT_CYCLES(SLOT)) dut (.clk_sys_in, .rst_in, .cfg_wr_in, .cfg_rd_in,
    .cfg_idx_in, .cfg_key_word_in, .cfg_wr_data_in, .local_unit_address_in, .network_type_in,
    .operating_mode_in, .repeater_index_in, .gpio_in, .auto_dest_address_in, .peer_address_in,
    .pending_slots_in, .rts_in, .downlink_req_in, .cfg_rd_data_out, .cfg_rd_valid_out,
    .cfg_err_out, .repeater_present_out, .serial_mode_out, .rs485_out, .full_duplex_out,
    .repeater_number_out, .encryption_on_out, .encryption_key_out, .destination_out,
    .peer_match_out, .tdma_active_out, .poll_address_out, .poll_slot_out, .in_poll_range_out,
    .cts_grant_out, .downlink_go_out);
  rnc_host host (.clk_in(clk_sys_in), .rd_data_in(cfg_rd_data_out), .rd_valid_in(cfg_rd_valid_out),
    .err_in(cfg_err_out), .wr_out(cfg_wr_in), .rd_out(cfg_rd_in), .idx_out(cfg_idx_in),
    .word_out(cfg_key_word_in), .data_out(cfg_wr_data_in));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Waits for a fresh slot, returns its address and length in cycles
  task automatic slot(output logic [15:0] adr, output logic [15:0] len);
    int n;
    n = 0;
    len = 16'h0000;
    while (poll_slot_out !== 1'b0 && n < 300) begin
      step(1);
      n++;
    end
    while (poll_slot_out !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    adr = poll_address_out;
    while (poll_slot_out === 1'b1 && n < 300) begin
      step(1);
      n++;
      len++;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    close_out();
  end
  initial begin
    step(16);
    rst_in = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (rows[i].wr) begin
        host.wr(rows[i].idx, 4'h0, rows[i].dat, e);
        chk(e, rows[i].err);
      end
      host.rd(rows[i].idx, d, v);
      chk(v, 1'b1);
      chk(d, rows[i].exp);
    end
    chk(serial_mode_out, RNC_SER_RS485_FULL);
    chk(rs485_out, 1'b1);
    chk(full_duplex_out, 1'b1);
    host.wr(8'hc8, 4'h0, 16'h0005, e);
    chk(e, 1'b1);
    host.wr(RNC_IDX_ENC_KEY, 4'hf, 16'hbeef, e);
    step(1);
    chk(encryption_key_out[255:240], 16'hbeef);
    chk(encryption_on_out, 1'b1);
    chk(repeater_number_out, 16'h00c8);
    host.wr(RNC_IDX_RPT_NUM_SRC, 4'h0, 16'h0001, e);
    step(2);
    chk(repeater_number_out, 16'h000a);
    gpio_in = 4'h3;
    step(3);
    chk(repeater_number_out, 16'h000a);
    chk(repeater_present_out, 1'b1);
    operating_mode_in = RNC_OP_REPEATER;
    step(3);
    chk(repeater_present_out, 1'b0);
    operating_mode_in = RNC_OP_SLAVE;
    step(3);
    chk(repeater_present_out, 1'b0);
    operating_mode_in = RNC_OP_MASTER;
    network_type_in = RNC_NET_P2P;
    local_unit_address_in = 16'h0000;
    step(3);
    chk(repeater_present_out, 1'b0);
    chk(destination_out, 16'h0777);
    local_unit_address_in = 16'h0001;
    peer_address_in = 16'h0005;
    step(3);
    chk(destination_out, 16'h1234);
    chk(peer_match_out, 1'b0);
    peer_address_in = 16'h1234;
    step(3);
    chk(peer_match_out, 1'b1);
    network_type_in = RNC_NET_P2MP;
    rts_in = 1'b1;
    downlink_req_in = 1'b1;
    step(2);
    chk(cts_grant_out, 1'b1);
    chk(downlink_go_out, 1'b1);
    rts_in = 1'b0;
    downlink_req_in = 1'b0;
    host.wr(RNC_IDX_TDMA_MAX_ADDR, 4'h0, 16'h0003, e);
    host.wr(RNC_IDX_ACCESS_MODE, 4'h0, 16'h0001, e);
    for (int k = 0; k < 3; k++) begin
      slot(a, l);
      chk(a, 16'h0002 + 16'(k % 2));
      chk(l, 16'(SLOT));
    end
    chk(in_poll_range_out, 1'b1);
    host.wr(RNC_IDX_TDMA_MAX_SLOTS, 4'h0, 16'h0002, e);
    host.wr(RNC_IDX_ACCESS_MODE, 4'h0, 16'h0002, e);
    slot(a, l);
    chk(l, 16'(2 * SLOT));
    local_unit_address_in = 16'h0005;
    step(4);
    chk(in_poll_range_out, 1'b0);
    // Second reset in mid-run must restore defaults
    rst_in = 1'b1;
    step(2);
    rst_in = 1'b0;
    host.rd(RNC_IDX_TDMA_MAX_ADDR, d, v);
    chk(d, RNC_RST_TDMA_MAX_ADDR);
    network_type_in = RNC_NET_P2P;
    host.wr(RNC_IDX_ACCESS_MODE, 4'h0, 16'h0001, e);
    step(6);
    chk(tdma_active_out, 1'b0);
    network_type_in = RNC_NET_MESH;
    step(3);
    chk(tdma_active_out, 1'b1);
    close_out();
  end
endmodule
